// ### hw/ivp_pkg.sv
package ivp_pkg;

    // ========================================
    // Source indices, in priority order
    localparam int NUM_SRC = 13;
    localparam int SRC_W = 4;
    localparam int PRIO_W = 5;
    localparam logic [3:0] SRC_RESET = 4'h0;
    localparam logic [3:0] SRC_SER_RX = 4'h1;
    localparam logic [3:0] SRC_SER_TX = 4'h2;
    localparam logic [3:0] SRC_PIN_A = 4'h3;
    localparam logic [3:0] SRC_PIN_B = 4'h4;
    localparam logic [3:0] SRC_KEY_WAKE = 4'h5;
    localparam logic [3:0] SRC_CAPTURE = 4'h6;
    localparam logic [3:0] SRC_COMPARE = 4'h7;
    localparam logic [3:0] SRC_TIMER_A = 4'h8;
    localparam logic [3:0] SRC_TIMER_2 = 4'h9;
    localparam logic [3:0] SRC_ADC = 4'hA;
    localparam logic [3:0] SRC_TIMER_1 = 4'hB;
    localparam logic [3:0] SRC_SW_BREAK = 4'hC;

    // Maskable sources are indices 1 to 11
    localparam int NUM_MASKABLE = 11;

    // ========================================
    // Priority numbers, index 12 down to 0
    localparam logic [NUM_SRC-1:0][4:0] PRIO_TABLE = {
        5'h11, 5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07,
        5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01
    };

    // ========================================
    // Vector byte locations, index 12 down to 0
    localparam logic [NUM_SRC-1:0][15:0] VEC_LO_TABLE = {
        16'hFFDC, 16'hFFE6, 16'hFFE8, 16'hFFEA, 16'hFFEC,
        16'hFFEE, 16'hFFF0, 16'hFFF2, 16'hFFF4, 16'hFFF6,
        16'hFFF8, 16'hFFFA, 16'hFFFC
    };
    localparam logic [NUM_SRC-1:0][15:0] VEC_HI_TABLE = {
        16'hFFDD, 16'hFFE7, 16'hFFE9, 16'hFFEB, 16'hFFED,
        16'hFFEF, 16'hFFF1, 16'hFFF3, 16'hFFF5, 16'hFFF7,
        16'hFFF9, 16'hFFFB, 16'hFFFD
    };

    // Unassigned levels 13..16 occupy this span and have no index
    localparam logic [15:0] VEC_RSV_TOP = 16'hFFE5;
    localparam logic [15:0] VEC_RSV_BOTTOM = 16'hFFDE;

    // Reset values
    localparam logic [15:0] VEC_IDLE = 16'h0000;
    localparam logic [4:0] PRIO_IDLE = 5'h00;

    // ========================================
    // Carriers
    typedef struct packed {
        logic ser_rx;
        logic ser_tx;
        logic capture;
        logic compare;
        logic timer_a;
        logic timer_2;
        logic adc;
        logic timer_1;
    } ivp_periph_type;

    typedef struct packed {
        logic pending;
        logic [SRC_W-1:0] src;
        logic [PRIO_W-1:0] prio;
        logic [15:0] lo_addr;
        logic [15:0] hi_addr;
    } ivp_vec_type;

endpackage

// ### hw/ivp_req_flag.sv
`timescale 1ns/1ns
`default_nettype none

module ivp_req_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic mclk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic set_pulse, // Source event
    input wire logic clear_pulse, // Vector taken by CPU
    output logic flag_d, // Next flag value
    output logic flag_q // Held request flag
);

    // ========================================
    // Sticky flag, set beats clear
    always_comb begin
        flag_d = set_pulse | (flag_q & ~clear_pulse);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= RESET_VAL;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule

`default_nettype wire

// ### hw/ivp_interrupt_vector_priority_map.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// RQ1 - Reset ranks first at priority 1 with its vector at FFFC (low) and FFFD (high).
// RQ2 - Serial receive ranks at priority 2 with its vector at FFFA and FFFB.
// RQ3 - Serial transmit ranks at priority 3 with its vector at FFF8 and FFF9.
// RQ4 - External pin A ranks at priority 4 with its vector at FFF6 and FFF7.
// RQ5 - External pin B ranks at priority 5 with its vector at FFF4 and FFF5.
// RQ6 - Key-on wake-up ranks at priority 6 with its vector at FFF2 and FFF3.
// RQ7 - Capture ranks at priority 7 with its vector at FFF0 and FFF1.
// RQ8 - Compare ranks at priority 8 with its vector at FFEE and FFEF.
// RQ9 - Timer A ranks at priority 9 with its vector at FFEC and FFED.
// RQ10 - Timer 2 ranks at priority 10 with its vector at FFEA and FFEB.
// RQ11 - A/D completion ranks at priority 11 with its vector at FFE8 and FFE9.
// RQ12 - Timer 1 ranks at priority 12 with its vector at FFE6 and FFE7.
// RQ13 - Levels 13 to 16 (FFE4 down to FFDE) have no source and are never chosen.
// RQ14 - The software break is lowest, level 17, with its vector at FFDC and FFDD.
// RQ15 - Among pending enabled requests the smallest priority number wins.
// RQ16 - A maskable request counts only while flagged and enabled; acceptance clears it.
module ivp_interrupt_vector_priority_map #(
    parameter int NUM_MASKABLE = ivp_pkg::NUM_MASKABLE
) (
    input wire logic mclk, // System clock, 25 MHz
    input wire logic rst_n, // Async reset, active low
    input wire ivp_pkg::ivp_periph_type periph_event, // Peripheral pulses
    input wire logic external_irq_pin_a, // Async pin, rising edge
    input wire logic external_irq_pin_b, // Async pin, rising edge
    input wire logic key_wakeup_pin, // Async pin, rising edge
    input wire logic software_break_instruction, // Break executed
    input wire logic [NUM_MASKABLE-1:0] src_enable, // Enables, index 1..11
    input wire logic vec_accept, // CPU took presented vector
    output ivp_pkg::ivp_vec_type vec_q // Winning vector to CPU
);

    localparam int N = ivp_pkg::NUM_SRC;

    // ========================================
    // Pin synchronisers and edge detect
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic [2:0] pin_prev_q;
    logic [2:0] pin_rise;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
        end else begin
            pin_meta_q <= {key_wakeup_pin, external_irq_pin_b,
                           external_irq_pin_a};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Previous level kept apart so the first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_q <= 3'h0;
        end else begin
            pin_prev_q <= pin_sync_q;
        end
    end

    always_comb begin
        pin_rise = pin_sync_q & ~pin_prev_q;
    end

    // ========================================
    // Event vector in priority index order
    logic [N-1:0] set_vec;
    logic [N-1:0] clr_vec;
    logic [N-1:0] flag_d;
    logic [N-1:0] flag_q;
    logic [N-1:0] enable_all;
    logic [N-1:0] req_d;

    always_comb begin
        set_vec = '0;
        // Reset flag is preset by reset itself, no later set
        set_vec[ivp_pkg::SRC_RESET] = 1'b0;
        // RQ2 serial receive
        set_vec[ivp_pkg::SRC_SER_RX] = periph_event.ser_rx;
        // RQ3 serial transmit
        set_vec[ivp_pkg::SRC_SER_TX] = periph_event.ser_tx;
        // RQ4 pin A
        set_vec[ivp_pkg::SRC_PIN_A] = pin_rise[0];
        // RQ5 pin B
        set_vec[ivp_pkg::SRC_PIN_B] = pin_rise[1];
        // RQ6 key wake-up
        set_vec[ivp_pkg::SRC_KEY_WAKE] = pin_rise[2];
        // RQ7 capture event
        set_vec[ivp_pkg::SRC_CAPTURE] = periph_event.capture;
        // RQ8 compare match
        set_vec[ivp_pkg::SRC_COMPARE] = periph_event.compare;
        // RQ9 timer A
        set_vec[ivp_pkg::SRC_TIMER_A] = periph_event.timer_a;
        // RQ10 timer 2
        set_vec[ivp_pkg::SRC_TIMER_2] = periph_event.timer_2;
        // RQ11 conversion done
        set_vec[ivp_pkg::SRC_ADC] = periph_event.adc;
        // RQ12 timer 1
        set_vec[ivp_pkg::SRC_TIMER_1] = periph_event.timer_1;
        // RQ14 software break
        set_vec[ivp_pkg::SRC_SW_BREAK] = software_break_instruction;
    end

    // ========================================
    // Clear of the source whose vector was taken
    always_comb begin
        clr_vec = '0;
        // RQ16 clear on accept
        if (vec_accept && vec_q.pending) begin
            clr_vec[vec_q.src] = 1'b1;
        end
    end

    // ========================================
    // One sticky flag per source
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_flag
            // RQ1 reset flag preset
            ivp_req_flag #(
                .RESET_VAL(gi == 0)
            ) u_flag (
                .mclk(mclk),
                .rst_n(rst_n),
                .set_pulse(set_vec[gi]),
                .clear_pulse(clr_vec[gi]),
                .flag_d(flag_d[gi]),
                .flag_q(flag_q[gi])
            );
        end
    endgenerate

    // ========================================
    // Masking
    always_comb begin
        // RQ16 request needs flag and enable
        enable_all = {1'b1, src_enable, 1'b1};
        // Looking at next flags keeps a just-taken vector off the port
        req_d = flag_d & enable_all;
    end

    // ========================================
    // Priority pick
    logic found;
    logic [ivp_pkg::SRC_W-1:0] win;

    always_comb begin
        found = 1'b0;
        win = '0;
        // RQ15 lowest index wins
        // RQ13 reserved levels have no index
        for (int i = N - 1; i >= 0; i--) begin
            if (req_d[i]) begin
                found = 1'b1;
                win = ivp_pkg::SRC_W'(i);
            end
        end
    end

    // ========================================
    // Winner decode, one arm per ranked source
    logic [ivp_pkg::PRIO_W-1:0] prio_d;
    logic [15:0] lo_d;
    logic [15:0] hi_d;

    always_comb begin
        prio_d = ivp_pkg::PRIO_IDLE;
        lo_d = ivp_pkg::VEC_IDLE;
        hi_d = ivp_pkg::VEC_IDLE;
        // Constant indices keep every arm a fixed table pick
        case (win)
            // RQ1 reset vector
            ivp_pkg::SRC_RESET: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_RESET];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_RESET];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_RESET];
            end
            // RQ2 serial receive
            ivp_pkg::SRC_SER_RX: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_SER_RX];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_SER_RX];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_SER_RX];
            end
            // RQ3 serial transmit
            ivp_pkg::SRC_SER_TX: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_SER_TX];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_SER_TX];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_SER_TX];
            end
            // RQ4 pin A
            ivp_pkg::SRC_PIN_A: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_PIN_A];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_PIN_A];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_PIN_A];
            end
            // RQ5 pin B
            ivp_pkg::SRC_PIN_B: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_PIN_B];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_PIN_B];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_PIN_B];
            end
            // RQ6 key wake-up
            ivp_pkg::SRC_KEY_WAKE: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_KEY_WAKE];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_KEY_WAKE];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_KEY_WAKE];
            end
            // RQ7 capture event
            ivp_pkg::SRC_CAPTURE: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_CAPTURE];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_CAPTURE];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_CAPTURE];
            end
            // RQ8 compare match
            ivp_pkg::SRC_COMPARE: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_COMPARE];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_COMPARE];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_COMPARE];
            end
            // RQ9 timer A
            ivp_pkg::SRC_TIMER_A: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_TIMER_A];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_TIMER_A];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_TIMER_A];
            end
            // RQ10 timer 2
            ivp_pkg::SRC_TIMER_2: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_TIMER_2];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_TIMER_2];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_TIMER_2];
            end
            // RQ11 conversion done
            ivp_pkg::SRC_ADC: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_ADC];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_ADC];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_ADC];
            end
            // RQ12 timer 1
            ivp_pkg::SRC_TIMER_1: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_TIMER_1];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_TIMER_1];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_TIMER_1];
            end
            // RQ14 software break
            ivp_pkg::SRC_SW_BREAK: begin
                prio_d = ivp_pkg::PRIO_TABLE[ivp_pkg::SRC_SW_BREAK];
                lo_d = ivp_pkg::VEC_LO_TABLE[ivp_pkg::SRC_SW_BREAK];
                hi_d = ivp_pkg::VEC_HI_TABLE[ivp_pkg::SRC_SW_BREAK];
            end
            // RQ13 unused codes idle
            default: begin
                prio_d = ivp_pkg::PRIO_IDLE;
                lo_d = ivp_pkg::VEC_IDLE;
                hi_d = ivp_pkg::VEC_IDLE;
            end
        endcase
    end

    // ========================================
    // Reserved span guard
    logic rsv_hit;
    logic present;

    always_comb begin
        // RQ13 reserved slots blocked
        // A bad table entry shows as idle rather than a jump into nothing
        rsv_hit = (lo_d >= ivp_pkg::VEC_RSV_BOTTOM)
                  && (lo_d <= ivp_pkg::VEC_RSV_TOP);
        present = found && !rsv_hit;
    end

    // ========================================
    // Registered vector toward the CPU
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vec_q.pending <= 1'b0;
            vec_q.src <= ivp_pkg::SRC_RESET;
            vec_q.prio <= ivp_pkg::PRIO_IDLE;
        end else begin
            // RQ15 winner presented
            vec_q.pending <= present;
            vec_q.src <= win;
            vec_q.prio <= present ? prio_d : ivp_pkg::PRIO_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vec_q.lo_addr <= ivp_pkg::VEC_IDLE;
            vec_q.hi_addr <= ivp_pkg::VEC_IDLE;
        end else if (present) begin
            // RQ15 winner vector bytes
            vec_q.lo_addr <= lo_d;
            vec_q.hi_addr <= hi_d;
        end else begin
            vec_q.lo_addr <= ivp_pkg::VEC_IDLE;
            vec_q.hi_addr <= ivp_pkg::VEC_IDLE;
        end
    end

endmodule

`default_nettype wire

// ### testbench/ivp_chk_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// Vector selection checks
module ivp_chk #(
    parameter int NUM_MASKABLE = 11
) (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Reset
    input wire ivp_pkg::ivp_periph_type periph_event, // Events
    input wire logic external_irq_pin_a, // Pin
    input wire logic external_irq_pin_b, // Pin
    input wire logic key_wakeup_pin, // Pin
    input wire logic software_break_instruction, // Break
    input wire logic [NUM_MASKABLE-1:0] src_enable, // Enables
    input wire logic vec_accept, // Take
    input wire ivp_pkg::ivp_vec_type vec_q // Vector
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_brk_take;
        vec_accept && vec_q.pending && vec_q.src == 4'hC;
    endsequence
    sequence s_pin_rise;
        !external_irq_pin_a ##1 external_irq_pin_a && src_enable[2];
    endsequence
    property p_rst_first;
        $rose(rst_n) |=> vec_q.pending && vec_q.src == 4'h0
            && vec_q.prio == 5'h01 && vec_q.lo_addr == 16'hFFFC
            && vec_q.hi_addr == 16'hFFFD;
    endproperty
    a_rst_first: assert property (p_rst_first) else $error("reset");
    property p_map;
        vec_q.pending |-> ((vec_q.src < 4'hC) ?
            (vec_q.prio == vec_q.src + 5'h01
            && vec_q.lo_addr == 16'hFFFC - 16'(2 * vec_q.src)) :
            (vec_q.src == 4'hC && vec_q.prio == 5'h11
            && vec_q.lo_addr == 16'hFFDC));
    endproperty
    a_map: assert property (p_map) else $error("map");
    property p_rsv;
        vec_q.pending |-> !(vec_q.lo_addr inside {[16'hFFDE:16'hFFE5]})
            && vec_q.hi_addr == vec_q.lo_addr + 16'h0001;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved");
    property p_rx;
        periph_event.ser_rx && src_enable[0] |=> vec_q.pending
            && vec_q.src <= 4'h1;
    endproperty
    a_rx: assert property (p_rx) else $error("rank");
    property p_t1;
        periph_event.timer_1 && src_enable[10] |=> vec_q.pending
            && vec_q.src <= 4'hB;
    endproperty
    a_t1: assert property (p_t1) else $error("timer");
    property p_brk_take;
        s_brk_take ##0 !software_break_instruction
            |=> !(vec_q.pending && vec_q.src == 4'hC);
    endproperty
    a_brk_take: assert property (p_brk_take) else $error("kept");
    property p_mask;
        vec_q.pending && vec_q.src inside {[4'h1:4'hB]}
            |-> (($past(src_enable) >> (vec_q.src - 4'h1)) & 1) != 0;
    endproperty
    a_mask: assert property (p_mask) else $error("mask");
    // Window covers both sync latencies and the take that may follow
    property p_pin_a;
        s_pin_rise |-> ##[2:5] vec_q.pending && vec_q.src <= 4'h3;
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("pin");
endmodule
bind ivp_interrupt_vector_priority_map ivp_chk #(
    .NUM_MASKABLE(NUM_MASKABLE)
) u_ivp_chk (.mclk, .rst_n, .periph_event, .external_irq_pin_a,
    .external_irq_pin_b, .key_wakeup_pin, .software_break_instruction,
    .src_enable, .vec_accept, .vec_q);
`default_nettype wire

// ### testbench/ivp_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ========================================
// CPU side: takes each presented vector
module ivp_cpu_model (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Reset
    input wire ivp_pkg::ivp_vec_type vec_q, // Presented
    input wire logic en, // May take
    input wire logic [3:0] dly, // Wait cycles
    output logic vec_accept, // Take pulse
    output logic [7:0] taken_q, // Count taken
    output ivp_pkg::ivp_vec_type last_q // Last taken
);
    logic [3:0] cnt_q;
    // Pulse drops at the take edge so a stale vector is never retaken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vec_accept <= 1'b0;
            cnt_q <= 4'h0;
            taken_q <= 8'h00;
            last_q <= '0;
        end else if (vec_accept) begin
            vec_accept <= 1'b0;
            cnt_q <= 4'h0;
            taken_q <= taken_q + 8'h01;
            last_q <= vec_q;
        end else if (en && vec_q.pending) begin
            if (cnt_q == dly) vec_accept <= 1'b1;
            else cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end
module tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, en = 1'b1, vec_accept;
    logic [12:0] req = '0;
    logic [10:0] src_enable = '1;
    logic [3:0] dly = 4'h0;
    logic [7:0] taken_q;
    int kn = 0, err_total = 0, n_checks = 0;
    ivp_pkg::ivp_vec_type vec_q, last_q;
    always #20 mclk = ~mclk;
    ivp_interrupt_vector_priority_map u_ivp_interrupt_vector_priority_map (
        .mclk, .rst_n, .src_enable, .vec_accept, .vec_q,
        .periph_event({req[1], req[2], req[6], req[7], req[8], req[9],
            req[10], req[11]}),
        .external_irq_pin_a(req[3]), .external_irq_pin_b(req[4]),
        .key_wakeup_pin(req[5]), .software_break_instruction(req[12]));
    ivp_cpu_model u_ivp_cpu_model (.mclk, .rst_n, .vec_q, .en, .dly,
        .vec_accept, .taken_q, .last_q);
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic pulse(input int s);
        @(negedge mclk) req[s] = 1'b1;
        @(negedge mclk) req[s] = 1'b0;
    endtask
    // Next take must carry the vector mapped for source index s
    task automatic wait_take(input int s);
        logic [15:0] lo;
        kn++;
        lo = (s == 12) ? 16'hFFDC : 16'hFFFC - 16'(2 * s);
        for (int i = 0; i < 40 && taken_q !== 8'(kn); i++) @(negedge mclk);
        if (taken_q !== 8'(kn)) begin
            err_total++;
            report_and_stop();
        end
        `CHK("src", 4'(s), last_q.src)
        `CHK("lo", lo, last_q.lo_addr)
        `CHK("hi", lo + 16'h0001, last_q.hi_addr)
        `CHK("prio", (s == 12) ? 5'h11 : 5'(s + 1), last_q.prio)
    endtask
    task automatic t_reset();
        wait_take(0);
    endtask
    task automatic t_each();
        for (int s = 1; s <= 12; s++) begin
            pulse(s);
            wait_take(s);
        end
    endtask
    // Sources 1 to 12 at once, slow CPU: taken strictly in rank order
    task automatic t_prio();
        en = 1'b0;
        dly = 4'h2;
        @(negedge mclk) req = 13'h1FFE;
        @(negedge mclk) req = '0;
        repeat (6) @(negedge mclk);
        en = 1'b1;
        for (int s = 1; s <= 12; s++) begin
            wait_take(s);
        end
    endtask
    task automatic t_mask();
        dly = 4'h0;
        src_enable = '0;
        pulse(11);
        repeat (8) @(negedge mclk);
        `CHK("masked", 1'b0, vec_q.pending)
        `CHK("idle prio", 5'h00, vec_q.prio)
        `CHK("idle lo", 16'h0000, vec_q.lo_addr)
        `CHK("idle hi", 16'h0000, vec_q.hi_addr)
        src_enable = '1;
        wait_take(11);
    endtask
    // Event in the very cycle of its own take: set wins, shown again
    task automatic t_rearm();
        pulse(11);
        for (int i = 0; i < 40 && vec_accept !== 1'b1; i++) @(negedge mclk);
        if (vec_accept !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        req[11] = 1'b1;
        @(negedge mclk) req[11] = 1'b0;
        wait_take(11);
        wait_take(11);
    endtask
    // Mid-run reset drops a pending source and restarts at reset vector
    task automatic t_rerun();
        en = 1'b0;
        pulse(8);
        @(negedge mclk) rst_n = 1'b0;
        @(negedge mclk);
        `CHK("rst pend", 1'b0, vec_q.pending)
        `CHK("rst prio", 5'h00, vec_q.prio)
        `CHK("rst lo", 16'h0000, vec_q.lo_addr)
        `CHK("rst hi", 16'h0000, vec_q.hi_addr)
        rst_n = 1'b1;
        en = 1'b1;
        kn = 0;
        wait_take(0);
        repeat (4) @(negedge mclk);
        `CHK("flushed", 1'b0, vec_q.pending)
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_each();
        t_prio();
        t_mask();
        t_rearm();
        t_rerun();
        report_and_stop();
    end
endmodule
`default_nettype wire
